// ---- inc/esr_pkg.sv ----
// esr_pkg: constants and types of the sensor result read-out block.
// assumes one register byte space shared by the i2c and spi slave engines.
package esr_pkg;

  // register offsets
  localparam logic [7:0] ADDR_STATUS   = 8'h1D;
  localparam logic [7:0] ADDR_PRESS_HI = 8'h1F;
  localparam logic [7:0] ADDR_PRESS_MD = 8'h20;
  localparam logic [7:0] ADDR_PRESS_LO = 8'h21;
  localparam logic [7:0] ADDR_TEMP_HI  = 8'h22;
  localparam logic [7:0] ADDR_TEMP_MD  = 8'h23;
  localparam logic [7:0] ADDR_TEMP_LO  = 8'h24;
  localparam logic [7:0] ADDR_HUM_HI   = 8'h25;
  localparam logic [7:0] ADDR_HUM_LO   = 8'h26;
  localparam logic [7:0] ADDR_RES_HI   = 8'h2A;
  localparam logic [7:0] ADDR_RES_LO   = 8'h2B;
  localparam logic [7:0] ADDR_CTRL     = 8'h71;

  // field positions and masks
  localparam int         RUN_BIT       = 4;
  localparam logic [7:0] CTRL_MASK     = 8'h1F;
  localparam logic [3:0] INDEX_LAST    = 4'h9;
  localparam int         SPI_RW_BIT    = 7;

  // reset values
  localparam logic [19:0] PT_RESET     = 20'h80000;
  localparam logic [15:0] HUM_RESET    = 16'h8000;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [3:0]  SYNC_RESET   = 4'hF;

  // fixed upper six bits of the i2c slave address
  localparam logic [5:0] I2C_ADDR_HIGH = 6'h3B;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // one finished conversion cycle from the sensing core
  typedef struct packed {
    logic [19:0] press;
    logic [19:0] temp;
    logic [15:0] hum;
    logic [9:0]  gas;
    logic [3:0]  gas_range;
    logic        heat_stab;
  } esr_result_type;

  typedef enum logic [3:0] {
    st_idle, st_dev, st_ack_out, st_rx, st_tx, st_ack_in,
    st_spi_cmd, st_spi_wr, st_spi_rd
  } esr_state_type;

endpackage : esr_pkg

// ---- logic/esr_readout.sv ----
// esr_readout: status/result registers with shadowing and i2c/spi slave.
// assumes the sensing core runs on core_clk; serial pins are asynchronous.
`timescale 1ns/1ps
module esr_readout (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    select_n,
  input  wire logic                    serial_clk_pin,
  input  wire logic                    serial_in_pin_i,
  output logic                         serial_in_pin_o,
  output logic                         serial_in_pin_oe,
  input  wire logic                    addr_lsb_pin_i,
  output logic                         addr_lsb_pin_o,
  output logic                         addr_lsb_pin_oe,
  input  wire logic                    spi_three_wire,
  input  wire logic                    forced_mode,
  input  wire logic                    conv_start,
  input  wire logic                    gas_slot,
  input  wire logic                    conv_done,
  input  wire esr_pkg::esr_result_type conv_result,
  output logic                         gas_launch,
  output logic                         measuring_busy
);
  import esr_pkg::*;

  // register read mux; unmapped offsets read as zero
  function automatic logic [7:0] read_reg(
    input logic [7:0]     a,
    input esr_result_type r,
    input logic           valid,
    input logic [7:0]     status,
    input logic [7:0]     ctrl_val
  );
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      ADDR_STATUS:   d = status;
      ADDR_PRESS_HI: d = r.press[19:12];
      ADDR_PRESS_MD: d = r.press[11:4];
      ADDR_PRESS_LO: d = {r.press[3:0], 4'h0};
      ADDR_TEMP_HI:  d = r.temp[19:12];
      ADDR_TEMP_MD:  d = r.temp[11:4];
      ADDR_TEMP_LO:  d = {r.temp[3:0], 4'h0};
      ADDR_HUM_HI:   d = r.hum[15:8];
      ADDR_HUM_LO:   d = r.hum[7:0];
      ADDR_RES_HI:   d = r.gas[9:2];
      ADDR_RES_LO:   d = {r.gas[1:0], valid, r.heat_stab, r.gas_range};
      ADDR_CTRL:     d = ctrl_val;
      default:       d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  // pin synchronisers: bit 0 clock, 1 data, 2 select, 3 address pin
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_c;

  // serial engine state
  esr_state_type state;
  logic [3:0]    cnt;
  logic [7:0]    sreg;
  logic [7:0]    txreg;
  logic [7:0]    ptr;
  logic          is_read;
  logic          want_addr;
  logic          ack_ok;
  logic          wr_strobe;
  logic [7:0]    wr_data;
  logic [7:0]    wr_addr;
  logic          rd_status;
  logic          i2c_off;

  // result side
  logic           pend;
  logic           pend_valid;
  esr_result_type pend_res;
  esr_result_type res_q;
  logic           gas_valid;
  logic           gas_real;
  logic           new_data;
  logic           gas_busy;
  logic [3:0]     meas_index;
  logic [7:0]     ctrl;

  // edge and condition decode
  wire       sck       = sync_b[0];
  wire       sda       = sync_b[1];
  wire       sel       = sync_b[2];
  wire       alsb      = sync_b[3];
  wire       sck_rise  = sck & ~sync_c[0];
  wire       sck_fall  = ~sck & sync_c[0];
  wire       i2c_on    = sel & ~i2c_off;
  wire       i2c_start = i2c_on & sck & sync_c[0] & sync_c[1] & ~sda;
  wire       i2c_stop  = i2c_on & sck & sync_c[0] & ~sync_c[1] & sda;
  wire       spi_begin = ~sel & sync_c[2];
  wire       spi_state = (state == st_spi_cmd) | (state == st_spi_wr) | (state == st_spi_rd);
  wire [7:0] next_sreg = {sreg[6:0], sda};
  wire       addr_hit  = next_sreg[7:1] == {I2C_ADDR_HIGH, alsb};
  wire [7:0] status    = {new_data, gas_busy, measuring_busy, 1'b0, meas_index};
  wire [7:0] rd_byte   = read_reg(ptr, res_q, gas_valid, status, ctrl);
  wire       spi_bit   = (cnt == 4'h0) ? rd_byte[7] : txreg[7];
  wire       lock      = state != st_idle;
  wire       apply     = pend & ~lock;
  wire       run_ok    = ctrl[RUN_BIT] & forced_mode & (ctrl[3:0] <= INDEX_LAST);
  wire       ctrl_wr   = wr_strobe & (wr_addr == ADDR_CTRL);

  // two-stage sync plus one history stage for edge finding
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync_a <= SYNC_RESET;
      sync_b <= SYNC_RESET;
      sync_c <= SYNC_RESET;
    end
    else
    begin
      sync_a <= {addr_lsb_pin_i, select_n, serial_in_pin_i, serial_clk_pin};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // a single low select sample locks out i2c; only reset reopens it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      i2c_off <= 1'b0;
    else if (~sel)
      i2c_off <= 1'b1;
  end

  // serial slave engine; the clock pin is only ever sampled, never driven
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state            <= st_idle;
      cnt              <= 4'h0;
      sreg             <= 8'h00;
      txreg            <= 8'h00;
      ptr              <= 8'h00;
      is_read          <= 1'b0;
      want_addr        <= 1'b1;
      ack_ok           <= 1'b0;
      wr_strobe        <= 1'b0;
      wr_data          <= 8'h00;
      wr_addr          <= 8'h00;
      rd_status        <= 1'b0;
      serial_in_pin_o  <= 1'b0;
      serial_in_pin_oe <= 1'b0;
      addr_lsb_pin_o   <= 1'b0;
      addr_lsb_pin_oe  <= 1'b0;
    end
    else
    begin
      wr_strobe <= 1'b0;
      rd_status <= 1'b0;
      if (i2c_start)
      begin
        state            <= st_dev;
        cnt              <= 4'h0;
        serial_in_pin_oe <= 1'b0;
      end
      else if (i2c_stop | (spi_state & sel) | (~i2c_on & ~spi_state & state != st_idle))
      begin
        state            <= st_idle;
        serial_in_pin_o  <= 1'b0;
        serial_in_pin_oe <= 1'b0;
        addr_lsb_pin_oe  <= 1'b0;
      end
      else if (spi_begin)
      begin
        state <= st_spi_cmd;
        cnt   <= 4'h0;
      end
      else
      begin
        unique case (state)
          st_idle: ;
          st_dev:
            if (sck_rise)
            begin
              sreg <= next_sreg;
              cnt  <= cnt + 4'h1;
            end
            else if (sck_fall & (cnt == BITS_PER_BYTE))
            begin
              if (sreg[7:1] == {I2C_ADDR_HIGH, alsb})
              begin
                serial_in_pin_oe <= 1'b1;
                is_read          <= sreg[0];
                want_addr        <= 1'b1;
                state            <= st_ack_out;
              end
              else
                state <= st_idle;
            end
          st_ack_out:
            if (sck_fall)
            begin
              cnt <= 4'h0;
              if (is_read)
              begin
                serial_in_pin_oe <= ~rd_byte[7];
                txreg            <= {rd_byte[6:0], 1'b0};
                ptr              <= ptr + 8'h01;
                rd_status        <= ptr == ADDR_STATUS;
                state            <= st_tx;
              end
              else
              begin
                serial_in_pin_oe <= 1'b0;
                state            <= st_rx;
              end
            end
          st_rx:
            if (sck_rise)
            begin
              sreg <= next_sreg;
              cnt  <= cnt + 4'h1;
            end
            else if (sck_fall & (cnt == BITS_PER_BYTE))
            begin
              serial_in_pin_oe <= 1'b1;
              state            <= st_ack_out;
              want_addr        <= ~want_addr;
              if (want_addr)
                ptr <= sreg;
              else
              begin
                wr_strobe <= 1'b1;
                wr_addr   <= ptr;
                wr_data   <= sreg;
              end
            end
          st_tx:
            if (sck_rise)
              cnt <= cnt + 4'h1;
            else if (sck_fall)
            begin
              if (cnt == BITS_PER_BYTE)
              begin
                serial_in_pin_oe <= 1'b0;
                state            <= st_ack_in;
              end
              else
              begin
                serial_in_pin_oe <= ~txreg[7];
                txreg            <= {txreg[6:0], 1'b0};
              end
            end
          st_ack_in:
            if (sck_rise)
              ack_ok <= ~sda;
            else if (sck_fall)
            begin
              cnt <= 4'h0;
              if (ack_ok)
              begin
                serial_in_pin_oe <= ~rd_byte[7];
                txreg            <= {rd_byte[6:0], 1'b0};
                ptr              <= ptr + 8'h01;
                rd_status        <= ptr == ADDR_STATUS;
                state            <= st_tx;
              end
              else
                state <= st_idle;
            end
          st_spi_cmd:
            if (sck_rise)
            begin
              sreg <= next_sreg;
              cnt  <= cnt + 4'h1;
              if (cnt == 4'h7)
              begin
                cnt   <= 4'h0;
                ptr   <= {1'b0, next_sreg[6:0]};
                state <= next_sreg[SPI_RW_BIT] ? st_spi_rd : st_spi_wr;
              end
            end
          st_spi_wr:
            if (sck_rise)
            begin
              sreg <= next_sreg;
              cnt  <= cnt + 4'h1;
              if (cnt == 4'h7)
              begin
                cnt       <= 4'h0;
                wr_strobe <= 1'b1;
                wr_addr   <= ptr;
                wr_data   <= next_sreg;
                state     <= st_spi_cmd;
              end
            end
          st_spi_rd:
            if (sck_rise)
              cnt <= (cnt == 4'h7) ? 4'h0 : cnt + 4'h1;
            else if (sck_fall)
            begin
              // data changes on falling edges, in both clock polarities
              serial_in_pin_o  <= spi_three_wire & spi_bit;
              serial_in_pin_oe <= spi_three_wire;
              addr_lsb_pin_o   <= spi_bit;
              addr_lsb_pin_oe  <= ~spi_three_wire;
              if (cnt == 4'h0)
              begin
                txreg     <= {rd_byte[6:0], 1'b0};
                ptr       <= ptr + 8'h01;
                rd_status <= ptr == ADDR_STATUS;
              end
              else
                txreg <= {txreg[6:0], 1'b0};
            end
          default:
            state <= st_idle;
        endcase
      end
    end
  end

  // control register: set-point index and gas run enable
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ctrl <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= wr_data & CTRL_MASK;
  end

  // gas slot handling: a slot without launch stays a dummy
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      gas_launch <= 1'b0;
      gas_real   <= 1'b0;
      meas_index <= 4'h0;
    end
    else
    begin
      gas_launch <= gas_slot & run_ok;
      if (gas_slot & run_ok)
      begin
        gas_real   <= 1'b1;
        meas_index <= ctrl[3:0];
      end
      else if (conv_start)
        gas_real <= 1'b0;
    end
  end

  // finished cycle waits here while a host transfer is open, so a burst
  // read never mixes bytes of two cycles; the cost is delayed status
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pend       <= 1'b0;
      pend_valid <= 1'b0;
      pend_res   <= '{PT_RESET, PT_RESET, HUM_RESET, 10'h000, 4'h0, 1'b0};
    end
    else if (conv_done)
    begin
      pend       <= 1'b1;
      pend_res   <= conv_result;
      pend_valid <= gas_real | (gas_slot & run_ok);
    end
    else if (apply)
      pend <= 1'b0;
  end

  // visible result registers and status flags; a set beats a clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      res_q          <= '{PT_RESET, PT_RESET, HUM_RESET, 10'h000, 4'h0, 1'b0};
      gas_valid      <= 1'b0;
      new_data       <= 1'b0;
      gas_busy       <= 1'b0;
      measuring_busy <= 1'b0;
    end
    else
    begin
      if (apply)
      begin
        res_q     <= pend_res;
        gas_valid <= pend_valid;
      end
      new_data       <= apply | (new_data & ~rd_status);
      gas_busy       <= (gas_slot & run_ok) | (gas_busy & ~apply);
      measuring_busy <= conv_start | (measuring_busy & ~apply);
    end
  end

endmodule : esr_readout

// ---- verification/esr_readout_sva.sv ----
// esr_readout_sva: port assertions for the result read-out block.
// assumes one core_clk domain; bound onto every esr_readout.
`timescale 1ns/1ps
module esr_readout_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic select_n,
  input wire logic spi_three_wire,
  input wire logic forced_mode,
  input wire logic conv_start,
  input wire logic gas_slot,
  input wire logic conv_done,
  input wire logic serial_in_pin_o,
  input wire logic serial_in_pin_oe,
  input wire logic addr_lsb_pin_oe,
  input wire logic gas_launch,
  input wire logic measuring_busy
);
  logic done_seen;
  logic spi_seen;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // a finished cycle since the last start, and any low select since reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      done_seen <= 1'b0;
      spi_seen  <= 1'b0;
    end
    else
    begin
      done_seen <= conv_done || (done_seen && !conv_start);
      spi_seen  <= spi_seen || !select_n;
    end
  end
  sequence s_launch;
    gas_slot ##1 gas_launch;
  endsequence
  a_launch_cause: assert property (gas_launch |-> $past(gas_slot) && $past(forced_mode))
    else $error("gas launch without slot and mode");
  a_launch_pulse: assert property (gas_launch |=> !gas_launch)
    else $error("gas launch longer than one cycle");
  a_busy_on_start: assert property (conv_start |=> measuring_busy)
    else $error("busy not set by cycle start");
  a_busy_rise_cause: assert property ($rose(measuring_busy) |-> $past(conv_start))
    else $error("busy rose without cycle start");
  a_busy_while_gas: assert property (s_launch |-> measuring_busy)
    else $error("busy low during gas conversion");
  a_busy_fall_done: assert property ($fell(measuring_busy) |-> done_seen)
    else $error("busy cleared before results arrived");
  a_reset_quiet: assert property (disable iff (1'b0)
      sys_rst |=> !measuring_busy && !gas_launch && !serial_in_pin_oe && !addr_lsb_pin_oe)
    else $error("outputs active after reset");
  a_sdo_idle: assert property (select_n [*6] |-> !addr_lsb_pin_oe)
    else $error("data pin driven while deselected");
  a_i2c_locked: assert property (spi_seen && !spi_three_wire |-> !serial_in_pin_oe)
    else $error("i2c drives data after spi select");
  a_open_drain: assert property (serial_in_pin_oe && !spi_three_wire |-> !serial_in_pin_o)
    else $error("data line driven high in i2c");
  c_launch: cover property (s_launch);
endmodule : esr_readout_sva

bind esr_readout esr_readout_sva u_esr_readout_sva (.core_clk, .sys_rst, .select_n, .spi_three_wire,
  .forced_mode, .conv_start, .gas_slot, .conv_done, .serial_in_pin_o, .serial_in_pin_oe,
  .addr_lsb_pin_oe, .gas_launch, .measuring_busy);

// ---- verification/esr_spi_host.sv ----
// esr_spi_host: behavioural spi master in the host's place.
// assumes core_clk paces it; a link period is nine core cycles, four low and five high.
`timescale 1ns/1ps
module esr_spi_host (
  input  wire logic core_clk,
  input  wire logic miso,
  output logic      csn,
  output logic      sck,
  output logic      mosi
);
  // select idles high so the block never sees a stray frame
  initial
  begin
    csn  = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
  // one frame; cpol sets mode 00 or 11 by the clock level at select fall
  task automatic xfer(input logic cpol, input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    @(posedge core_clk) sck <= cpol;
    repeat (4) @(posedge core_clk);
    csn <= 1'b0;
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        @(posedge core_clk) mosi <= tx[i][k];
        sck <= 1'b0;
        repeat (4) @(posedge core_clk);
        sck <= 1'b1;
        // sampled late in the high phase: the block answers on synchronised falls
        repeat (4) @(posedge core_clk);
        b[k] = miso;
      end
      rx.push_back(b);
    end
    @(posedge core_clk) sck <= cpol;
    repeat (4) @(posedge core_clk);
    csn <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : xfer
endmodule : esr_spi_host

// ---- verification/testbench.sv ----
// testbench: spi host model plus a behavioural register image against esr_readout.
// assumes esr_spi_host and the bound checker; spi 4-wire and 3-wire, no i2c traffic.
`timescale 1ns/1ps
module testbench;
  import esr_pkg::*;
  logic           core_clk    = 1'b0;
  logic           sys_rst     = 1'b1;
  logic           forced_mode = 1'b0;
  logic           conv_start  = 1'b0;
  logic           gas_slot    = 1'b0;
  logic           conv_done   = 1'b0;
  esr_result_type conv_result = '0;
  logic           last_sdo    = 1'b0;
  logic           mode11      = 1'b0;
  logic           last_sdi    = 1'b0;
  logic           three_w     = 1'b0;
  wire            sdi_w, miso_w;
  logic [7:0]     ctrl;
  esr_result_type nr;
  wire            csn, sck, mosi, sdo_w, sdi_o, sdi_oe, sdo_o, sdo_oe, gas_launch, measuring_busy;
  int             n_errors     = 0;
  int             total_checks = 0;
  int             seed         = 67;
  int             cycles       = 0;
  int             exp_reg [0:127];
  int             exp_mask [0:127];
  logic [7:0]     tx [$];
  logic [7:0]     rx [$];

  always #20 core_clk = ~core_clk;
  // no pull on the data pin: once released it shows the inverse of its last bit
  always @(posedge core_clk) if (sdo_oe) last_sdo <= sdo_o;
  assign sdo_w = sdo_oe ? sdo_o : ~last_sdo;
  // in 3-wire mode the read data comes back on the shared data pin
  always @(posedge core_clk) if (sdi_oe) last_sdi <= sdi_o;
  assign sdi_w  = sdi_oe ? sdi_o : ~last_sdi;
  assign miso_w = three_w ? sdi_w : sdo_w;

  esr_spi_host u_esr_spi_host (.core_clk(core_clk), .miso(miso_w), .csn(csn), .sck(sck), .mosi(mosi));
  esr_readout u_esr_readout (.core_clk(core_clk), .sys_rst(sys_rst), .select_n(csn), .serial_clk_pin(sck),
    .serial_in_pin_i(mosi), .serial_in_pin_o(sdi_o), .serial_in_pin_oe(sdi_oe), .addr_lsb_pin_i(sdo_w),
    .addr_lsb_pin_o(sdo_o), .addr_lsb_pin_oe(sdo_oe), .spi_three_wire(three_w), .forced_mode(forced_mode),
    .conv_start(conv_start), .gas_slot(gas_slot), .conv_done(conv_done), .conv_result(conv_result),
    .gas_launch(gas_launch), .measuring_busy(measuring_busy));

  // hang guard, sized well above the roughly 30k cycles the tests need
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic check(input string what, input int exp, input logic [7:0] got, input int mask = 255);
    total_checks++;
    if ((got & mask[7:0]) !== (exp[7:0] & mask[7:0]))
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp[7:0], got);
    end
  endtask : check

  function automatic esr_result_type rand_result();
    logic [95:0] rr;
    rr = {$random(seed), $random(seed), $random(seed)};
    return rr[70:0];
  endfunction : rand_result

  // burst read compared with the image; reading status consumes the fresh flag
  task automatic read_regs(input int a, input int n);
    tx = {8'h80 | a[7:0]};
    repeat (n) tx.push_back(8'h00);
    u_esr_spi_host.xfer(mode11, tx, rx);
    for (int i = 0; i < n; i++)
      check($sformatf("reg %h", a + i), exp_reg[a + i], rx[i + 1], exp_mask[a + i]);
    if (a <= 'h1D && a + n > 'h1D) exp_reg['h1D] &= 'h7F;
  endtask : read_regs

  // two address/data pairs in one frame; only the control byte is writable
  task automatic write2(input logic [7:0] a1, input logic [7:0] d1, input logic [7:0] a2, input logic [7:0] d2);
    tx = {a1 & 8'h7F, d1, a2 & 8'h7F, d2};
    u_esr_spi_host.xfer(mode11, tx, rx);
    if (a1 == 8'h71) exp_reg['h71] = d1 & 8'h1F;
    if (a2 == 8'h71) exp_reg['h71] = d2 & 8'h1F;
  endtask : write2

  task automatic load_model(input esr_result_type r, input logic go, input logic [3:0] setp);
    exp_reg['h1F] = r.press[19:12];
    exp_reg['h20] = r.press[11:4];
    exp_reg['h21] = {r.press[3:0], 4'h0};
    exp_reg['h22] = r.temp[19:12];
    exp_reg['h23] = r.temp[11:4];
    exp_reg['h24] = {r.temp[3:0], 4'h0};
    exp_reg['h25] = r.hum[15:8];
    exp_reg['h26] = r.hum[7:0];
    exp_reg['h2A] = r.gas[9:2];
    exp_reg['h2B] = {r.gas[1:0], go, r.heat_stab, r.gas_range};
    exp_reg['h1D] = go ? {4'h8, setp} : 'h80;
    exp_mask['h1D] = go ? 'hFF : 'hF0;
    exp_mask['h2A] = go ? 'hFF : 'h00;
    exp_mask['h2B] = go ? 'hFF : 'h20;
  endtask : load_model

  // one full cycle: start, gas slot, status mid-run, then results
  task automatic convert(input logic [7:0] c, input logic fm);
    logic go;
    go = fm && c[4] && c[3:0] <= 4'h9;
    nr = rand_result();
    @(posedge core_clk) forced_mode <= fm;
    conv_start <= 1'b1;
    @(posedge core_clk) conv_start <= 1'b0;
    gas_slot <= 1'b1;
    @(posedge core_clk) gas_slot <= 1'b0;
    #1 check("gas_launch", go, gas_launch);
    check("busy", 1, measuring_busy);
    exp_reg['h1D] = go ? {4'h6, c[3:0]} : 'h20;
    exp_mask['h1D] = go ? 'hFF : 'hE0;
    read_regs('h1D, 1);
    @(posedge core_clk) conv_result <= nr;
    conv_done <= 1'b1;
    @(posedge core_clk) conv_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    load_model(nr, go, c[3:0]);
    #1 check("busy", 0, measuring_busy);
  endtask : convert

  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      exp_reg[i] = 0;
      exp_mask[i] = 'hFF;
    end
    exp_reg['h1F] = 'h80;
    exp_reg['h22] = 'h80;
    exp_reg['h25] = 'h80;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    read_regs('h1D, 15);
    read_regs('h71, 1);
    $display("test reset_values done");
    // set-points 0..11 with run set, then run clear, then forced mode off
    for (int k = 0; k < 14; k++)
    begin
      ctrl = 8'($random(seed));
      ctrl[4] = (k != 12);
      ctrl[3:0] = 4'((k < 12) ? k : 5);
      mode11 = k[0];
      three_w <= k[1];
      write2(8'h71, ctrl, 8'h1F, 8'($random(seed)));
      read_regs('h71, 1);
      convert(ctrl, k != 13);
      read_regs('h1D, 15);
      read_regs('h1D, 1);
    end
    $display("test conversions done");
    nr = rand_result();
    tx = {8'h9F, 8'h00, 8'h00, 8'h00};
    fork
      u_esr_spi_host.xfer(1'b0, tx, rx);
      begin
        repeat (80) @(posedge core_clk);
        conv_result <= nr;
        conv_done <= 1'b1;
        @(posedge core_clk) conv_done <= 1'b0;
      end
    join
    for (int i = 0; i < 3; i++)
      check("shadow", exp_reg['h1F + i], rx[i + 1]);
    load_model(nr, 1'b0, 4'h0);
    read_regs('h1F, 3);
    $display("test shadow done");
    close_out();
  end
endmodule : testbench
